// file: liusr_map.vh
// Address map, field positions, reset values and counts of the
// line-interface status and pulse-segment register bank.
// Assumes a five-bit register address from the serial host port.
`ifndef LIUSR_MAP_VH
`define LIUSR_MAP_VH

// Register addresses
`define LIUSR_ADDR_CHG_STATUS 5'h06
`define LIUSR_ADDR_CABLE_LOSS 5'h07
`define LIUSR_ADDR_SEG_ONE    5'h08
`define LIUSR_ADDR_SEG_TWO    5'h09

// Reset values
`define LIUSR_RST_CHG_STATUS  8'h00
`define LIUSR_RST_CABLE_LOSS  6'h00
`define LIUSR_RST_SEG_ONE     8'h00
`define LIUSR_RST_SEG_TWO     8'h00

// Change-status bit positions
`define LIUSR_BIT_DRV_MON     6
`define LIUSR_BIT_FIFO_LIM    5
`define LIUSR_BIT_CODE_VIOL   4
`define LIUSR_BIT_LOOP_CODE   3
`define LIUSR_BIT_ALL_ONES    2
`define LIUSR_BIT_SIG_LOSS    1
`define LIUSR_BIT_PAT_SYNC    0

// Widths and fields
`define LIUSR_NUM_SRC         7
`define LIUSR_CABLE_W         6
`define LIUSR_AMP_W           7
`define LIUSR_AMP_SIGN        6
`define LIUSR_FIFO_PTR_W      6

// Counts
`define LIUSR_FIFO_LIM_GAP    6'h03
`define LIUSR_LAST_SEG        3'h7

`endif

// file: liusr_change_det.v
// Change detector for the live alarm sources: one latched flag per
// source, set on any transition, cleared by a host read.
// Assumes sources are synchronous to core_clk.
`timescale 1ns/1ps
`include "liusr_map.vh"

module liusr_change_det
(
   // Clock, reset, enable
   input  wire                      core_clk,
   input  wire                      rst,
   input  wire                      ce,
   // Live sources
   input  wire [`LIUSR_NUM_SRC-1:0] srcLevel,
   // Host read of the status register
   input  wire                      clearReq,
   // Latched change flags
   output reg  [`LIUSR_NUM_SRC-1:0] chgFlag_q
);

   reg  [`LIUSR_NUM_SRC-1:0] srcPrev_q;   // Level seen last cycle
   reg                       armed_q;     // Previous level is valid
   wire [`LIUSR_NUM_SRC-1:0] srcEdge;     // Transition this cycle
   wire [`LIUSR_NUM_SRC-1:0] chgFlag_d;   // Next flag value

   // First cycle after reset only samples, so a source that is
   // already asserted does not look like a change
   assign srcEdge = armed_q ? (srcLevel ^ srcPrev_q) : {`LIUSR_NUM_SRC{1'b0}};

   // New edge wins over the read clear
   assign chgFlag_d = srcEdge | (chgFlag_q & {`LIUSR_NUM_SRC{~clearReq}});

   // Flag and history registers
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         srcPrev_q <= {`LIUSR_NUM_SRC{1'b0}};
         armed_q   <= 1'b0;
         chgFlag_q <= {`LIUSR_NUM_SRC{1'b0}};
      end
      else if (ce)
      begin
         srcPrev_q <= srcLevel;
         armed_q   <= 1'b1;
         chgFlag_q <= chgFlag_d;
      end
   end

endmodule

// file: liusr_pulse_seq.v
// Arbitrary transmit pulse sequencer: steps through eight amplitude
// segments that together fill one master clock period.
// Assumes the clock multiplier gives a period-start and a step strobe.
`timescale 1ns/1ps
`include "liusr_map.vh"

module liusr_pulse_seq
(
   // Clock, reset, enable
   input  wire                       core_clk,
   input  wire                       rst,
   input  wire                       ce,
   // Timing strobes
   input  wire                       periodStart,
   input  wire                       segStep,
   // Mode and amplitudes, segment one in the low bits
   input  wire                       arbMode,
   input  wire [8*`LIUSR_AMP_W-1:0]  segAmpAll,
   // Current segment
   output reg  [2:0]                 segIdx_q,
   output reg  [`LIUSR_AMP_W-1:0]    segAmp_q,
   output reg                        segBusy_q
);

   reg  [2:0]              segIdx_d;   // Next segment index
   reg                     segBusy_d;  // Next busy state
   wire [`LIUSR_AMP_W-1:0] segPick;    // Amplitude of next segment

   assign segPick = segAmpAll[segIdx_d*`LIUSR_AMP_W +: `LIUSR_AMP_W];

   // Period start restarts at segment one; last step ends the pulse
   always @*
   begin
      segIdx_d  = segIdx_q;
      segBusy_d = segBusy_q;
      if (periodStart)
      begin
         segIdx_d  = 3'h0;
         segBusy_d = 1'b1;
      end
      else if (segStep && segBusy_q)
      begin
         if (segIdx_q == `LIUSR_LAST_SEG)
            segBusy_d = 1'b0;
         else
            segIdx_d = segIdx_q + 3'h1;
      end
   end

   // Outputs; amplitude zero outside arbitrary mode or between pulses
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         segIdx_q  <= 3'h0;
         segBusy_q <= 1'b0;
         segAmp_q  <= {`LIUSR_AMP_W{1'b0}};
      end
      else if (ce)
      begin
         segIdx_q  <= segIdx_d;
         segBusy_q <= segBusy_d & arbMode;
         segAmp_q  <= (segBusy_d && arbMode) ? segPick : {`LIUSR_AMP_W{1'b0}};
      end
   end

endmodule

// file: liusr_regs.v
// Status and pulse-segment register bank of the line interface unit:
// latched change status, cable loss estimate, segment one and two
// amplitudes, and the arbitrary pulse sequencer they feed.
// Assumes the serial host port decodes frames into a five-bit address
// with one-cycle read and write strobes, all on core_clk.
`timescale 1ns/1ps
`include "liusr_map.vh"

// How it works
// - Driver monitor change sets status bit six
// - FIFO limit change sets status bit five
// - Code violation change sets status bit four
// - Loop code change sets status bit three
// - All-ones change sets status bit two
// - Signal loss change sets status bit one
// - Pattern sync change sets status bit zero
// - Reading status clears it; bit seven zero
// - Six-bit cable loss word at seven
// - Cable loss follows chosen equalizer setting
// - Eight segments fill one master period
// - Amplitude is seven-bit sign and magnitude
// - Segment one amplitude register, resets zero
// - Segment two amplitude register, resets zero
// - Segments shape output only in arbitrary mode
// - Enabled source transition raises the interrupt
module liusr_regs
(
   // Clock, reset, enable
   input  wire                         core_clk,
   input  wire                         rst,
   input  wire                         ce,
   // Host register port
   input  wire [4:0]                   hostAddr,
   input  wire                         hostWr,
   input  wire                         hostRd,
   input  wire [7:0]                   hostWrData,
   output reg  [7:0]                   hostRdData_q,
   output reg                          hostRdValid_q,
   output reg                          hostRdHit_q,
   // Live status sources
   input  wire                         driver_monitor_state,
   input  wire                         code_violation_state,
   input  wire                         loop_code_state,
   input  wire                         all_ones_state,
   input  wire                         signal_loss_state,
   input  wire                         pattern_sync_state,
   // Jitter FIFO pointers
   input  wire [`LIUSR_FIFO_PTR_W-1:0] fifoWrPtr,
   input  wire [`LIUSR_FIFO_PTR_W-1:0] fifoRdPtr,
   // Receive equalizer choice
   input  wire [`LIUSR_CABLE_W-1:0]    eqSetting,
   input  wire                         eqSettingValid,
   // Interrupt enables and request
   input  wire [`LIUSR_NUM_SRC-1:0]    irqEnable,
   output wire                         irqRequest,
   // Pulse shaper
   input  wire                         arbPulseMode,
   input  wire                         periodStart,
   input  wire                         segStep,
   input  wire [6*`LIUSR_AMP_W-1:0]    segRestAmp,
   output wire [2:0]                   segIdx,
   output wire [`LIUSR_AMP_W-1:0]      segAmp,
   output wire                         segActive,
   output reg                          segSign_q,
   output reg  [`LIUSR_AMP_W-2:0]      segMag_q,
   // Segment registers for the shaper
   output wire [`LIUSR_AMP_W-1:0]      segment_one_amplitude,
   output wire [`LIUSR_AMP_W-1:0]      segment_two_amplitude
);

   // FIFO pointers within the limit gap either way round
   function fifo_near;
      input [`LIUSR_FIFO_PTR_W-1:0] wrPtr;
      input [`LIUSR_FIFO_PTR_W-1:0] rdPtr;
      reg   [`LIUSR_FIFO_PTR_W-1:0] gapFwd;
      reg   [`LIUSR_FIFO_PTR_W-1:0] gapBack;
      begin
         gapFwd    = wrPtr - rdPtr;
         gapBack   = rdPtr - wrPtr;
         fifo_near = (gapFwd <= `LIUSR_FIFO_LIM_GAP) ||
                     (gapBack <= `LIUSR_FIFO_LIM_GAP);
      end
   endfunction

   // Address compare shared by read and write decode
   function addr_is;
      input [4:0] addr;
      input [4:0] target;
      begin
         addr_is = (addr == target);
      end
   endfunction

   // Register state
   reg  [`LIUSR_CABLE_W-1:0] cable_attenuation_word_q; // Cable loss
   reg  [7:0]                segOneReg_q;   // Segment one, bit 7 spare
   reg  [7:0]                segTwoReg_q;   // Segment two, bit 7 spare
   reg  [7:0]                rdMux;         // Read data before flop
   reg                       rdHit;         // Address belongs here

   // Decode
   wire selStatus;   // Change-status address
   wire selCable;    // Cable loss address
   wire selSegOne;   // Segment one address
   wire selSegTwo;   // Segment two address
   wire statusRead;  // Host read of change status this cycle
   wire fifoLimit;   // Live FIFO limit condition

   // Change detector wiring
   wire [`LIUSR_NUM_SRC-1:0] srcLevel;  // Live levels by bit position
   wire [`LIUSR_NUM_SRC-1:0] chgFlag;   // Latched change flags

   // Sequencer wiring
   wire [8*`LIUSR_AMP_W-1:0] segAmpAll; // All eight amplitudes

   assign selStatus = addr_is(hostAddr, `LIUSR_ADDR_CHG_STATUS);
   assign selCable  = addr_is(hostAddr, `LIUSR_ADDR_CABLE_LOSS);
   assign selSegOne = addr_is(hostAddr, `LIUSR_ADDR_SEG_ONE);
   assign selSegTwo = addr_is(hostAddr, `LIUSR_ADDR_SEG_TWO);

   // A read only clears when the bank is running
   assign statusRead = hostRd & selStatus & ce;

   // FIFO limit is derived here from the live pointers
   assign fifoLimit = fifo_near(fifoWrPtr, fifoRdPtr);

   // Sources placed at their status bit positions
   assign srcLevel[`LIUSR_BIT_DRV_MON]   = driver_monitor_state;
   assign srcLevel[`LIUSR_BIT_FIFO_LIM]  = fifoLimit;
   assign srcLevel[`LIUSR_BIT_CODE_VIOL] = code_violation_state;
   assign srcLevel[`LIUSR_BIT_LOOP_CODE] = loop_code_state;
   assign srcLevel[`LIUSR_BIT_ALL_ONES]  = all_ones_state;
   assign srcLevel[`LIUSR_BIT_SIG_LOSS]  = signal_loss_state;
   assign srcLevel[`LIUSR_BIT_PAT_SYNC]  = pattern_sync_state;

   // Latched change flags; an edge in the read cycle survives the
   // clear, so no transition is lost between two host polls
   liusr_change_det changeDet
   (
      .core_clk  (core_clk),
      .rst       (rst),
      .ce        (ce),
      .srcLevel  (srcLevel),
      .clearReq  (statusRead),
      .chgFlag_q (chgFlag)
   );

   // Interrupt on any enabled latched transition; stays up until
   // the host reads the status register
   assign irqRequest = |(chgFlag & irqEnable);

   // Cable loss word tracks the equalizer whenever it settles
   always @(posedge core_clk)
   begin
      if (rst)
         cable_attenuation_word_q <=
            `LIUSR_RST_CABLE_LOSS;
      else if (ce && eqSettingValid)
         cable_attenuation_word_q <= eqSetting;
   end

   // Segment amplitude registers, host writable
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         segOneReg_q <= `LIUSR_RST_SEG_ONE;
         segTwoReg_q <= `LIUSR_RST_SEG_TWO;
      end
      else if (ce && hostWr)
      begin
         // Spare top bit is stored too, so it reads back
         if (selSegOne)
            segOneReg_q <= hostWrData;
         if (selSegTwo)
            segTwoReg_q <= hostWrData;
      end
   end

   assign segment_one_amplitude = segOneReg_q[`LIUSR_AMP_W-1:0];
   assign segment_two_amplitude = segTwoReg_q[`LIUSR_AMP_W-1:0];

   // Read multiplexer; unused status and cable bits and foreign addresses give zero, spare segment bits read back
   always @*
   begin
      rdMux = 8'h00;
      rdHit = 1'b1;
      case (1'b1)
         selStatus:
            rdMux = {1'b0, chgFlag};
         selCable:
            rdMux = {2'b00, cable_attenuation_word_q};
         selSegOne:
            rdMux = segOneReg_q;
         selSegTwo:
            rdMux = segTwoReg_q;
         default:
            rdHit = 1'b0;
      endcase
   end

   // Registered read answer, one cycle after the strobe; the data
   // returned is the flag value before the clear of that same read
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         hostRdData_q  <= 8'h00;
         hostRdValid_q <= 1'b0;
         hostRdHit_q   <= 1'b0;
      end
      else if (ce)
      begin
         hostRdValid_q <= hostRd;
         hostRdHit_q   <= hostRd & rdHit;
         if (hostRd)
            hostRdData_q <= rdMux;
      end
   end

   // Segments three to eight come from the neighbouring bank
   assign segAmpAll = {segRestAmp,
                       segment_two_amplitude,
                       segment_one_amplitude};

   // Eight-step sequencer over one master clock period
   liusr_pulse_seq pulseSeq
   (
      .core_clk    (core_clk),
      .rst         (rst),
      .ce          (ce),
      .periodStart (periodStart),
      .segStep     (segStep),
      .arbMode     (arbPulseMode),
      .segAmpAll   (segAmpAll),
      .segIdx_q    (segIdx),
      .segAmp_q    (segAmp),
      .segBusy_q   (segActive)
   );

   // Sign and magnitude split of the live amplitude for the DAC;
   // one cycle behind segAmp, gated by the mode a second time so a
   // mode drop mid-pulse silences the driver at once
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         segSign_q <= 1'b0;
         segMag_q  <= {(`LIUSR_AMP_W-1){1'b0}};
      end
      else if (ce)
      begin
         if (arbPulseMode)
         begin
            segSign_q <= segAmp[`LIUSR_AMP_SIGN];
            segMag_q  <= segAmp[`LIUSR_AMP_SIGN-1:0];
         end
         else
         begin
            segSign_q <= 1'b0;
            segMag_q  <= {(`LIUSR_AMP_W-1){1'b0}};
         end
      end
   end

endmodule

// file: liusr_chk_assertions.sv
// Port-level checker for the status and pulse-segment register bank.
// Assumes it is bound to liusr_regs and sees only its ports.
`timescale 1ns/1ps
module liusr_chk
(
   // Clock, reset, enable
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       ce,
   // Host port
   input wire logic [4:0] hostAddr,
   input wire logic       hostWr,
   input wire logic       hostRd,
   input wire logic [7:0] hostWrData,
   input wire logic [7:0] hostRdData_q,
   input wire logic       hostRdValid_q,
   input wire logic       hostRdHit_q,
   // Status and interrupt
   input wire logic       signal_loss_state,
   input wire logic [6:0] irqEnable,
   input wire logic       irqRequest,
   // Shaper
   input wire logic       arbPulseMode,
   input wire logic       periodStart,
   input wire logic       segStep,
   input wire logic [2:0] segIdx,
   input wire logic [6:0] segAmp,
   input wire logic       segActive,
   input wire logic [6:0] segment_one_amplitude
);
   // One clock domain, so one clocking and one disable
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_rd_valid;
      ce && hostRd |=> hostRdValid_q;
   endproperty
   a_rd_valid: assert property (p_rd_valid)
      else $error("read strobe not answered");
   property p_hit;
      hostRdValid_q |-> hostRdHit_q == ($past(hostAddr) inside {[5'h06:5'h09]});
   endproperty
   a_hit: assert property (p_hit)
      else $error("read hit flag wrong");
   property p_stat7;
      hostRdValid_q && $past(hostAddr) == 5'h06 |-> !hostRdData_q[7];
   endproperty
   a_stat7: assert property (p_stat7)
      else $error("status bit seven set");
   property p_seg1;
      ce && hostWr && hostAddr == 5'h08
         |=> {1'b0, segment_one_amplitude} == ($past(hostWrData) & 8'h7f);
   endproperty
   a_seg1: assert property (p_seg1)
      else $error("segment one write lost");
   // Previous edge must not be reset: first edge only samples sources
   property p_irq;
      ce && $past(ce) && !$past(rst) && $changed(signal_loss_state) && irqEnable[1]
         |=> irqRequest;
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled change gave no request");
   property p_arb_off;
      ce && !arbPulseMode |=> !segActive && segAmp == 7'h00;
   endproperty
   a_arb_off: assert property (p_arb_off)
      else $error("shaper active outside arbitrary mode");
   property p_period;
      ce && periodStart && arbPulseMode
         |=> segIdx == 3'h0 && segActive && segAmp == $past(segment_one_amplitude);
   endproperty
   a_period: assert property (p_period)
      else $error("period start not at segment one");
   property p_step;
      ce && segStep && !periodStart && arbPulseMode && segActive && segIdx != 3'h7
         |=> segIdx == $past(segIdx) + 3'h1;
   endproperty
   a_step: assert property (p_step)
      else $error("segment step wrong");
endmodule

// file: liusr_host_model.sv
// Host processor model: byte reads and writes on the register port.
// Assumes one-cycle strobes and a read answer one cycle later.
`timescale 1ns/1ps
module liusr_host_model
(
   // Clock
   input  wire logic       core_clk,
   // Requests
   output logic [4:0]      hostAddr,
   output logic            hostWr,
   output logic            hostRd,
   output logic [7:0]      hostWrData,
   // Answer
   input  wire logic [7:0] hostRdData_q,
   input  wire logic       hostRdValid_q,
   input  wire logic       hostRdHit_q
);
   // Idle bus
   initial
   begin
      hostAddr = 5'h1f;
      hostWr = 1'b0;
      hostRd = 1'b0;
      hostWrData = 8'h00;
   end
   // Released lines show the inverse, never a stale match
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      hostAddr = a;
      hostWrData = d;
      hostWr = 1'b1;
      @(posedge core_clk);
      #1;
      hostWr = 1'b0;
      hostAddr = ~a;
      hostWrData = ~d;
   endtask
   // Answer latency is fixed at one cycle
   task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic h);
      @(posedge core_clk);
      #1;
      hostAddr = a;
      hostRd = 1'b1;
      @(posedge core_clk);
      #1;
      hostRd = 1'b0;
      hostAddr = ~a;
      d = hostRdValid_q ? hostRdData_q : 8'hxx;
      h = hostRdValid_q ? hostRdHit_q : 1'bx;
   endtask
endmodule

// file: liusr_regs_tb.sv
// Self-checking bench for the status and pulse-segment register bank.
// Assumes the host model carries all register traffic.
`timescale 1ns/1ps
module liusr_regs_tb;
   // Bench controls
   logic        core_clk, rst, ce, eqSettingValid, arbPulseMode;
   logic        periodStart, segStep, hostWr, hostRd, segSign_q;
   logic        hostRdValid_q, hostRdHit_q, irqRequest, segActive, rdHit;
   logic [4:0]  hostAddr;
   logic [7:0]  hostWrData, hostRdData_q, rdData;
   // Sources, placed as in the status register
   logic [6:0]  src, irqEnable;
   wire         driver_monitor_state = src[6];
   wire         code_violation_state = src[4];
   wire         loop_code_state      = src[3];
   wire         all_ones_state       = src[2];
   wire         signal_loss_state    = src[1];
   wire         pattern_sync_state   = src[0];
   // Pointers, equalizer, shaper
   logic [5:0]  fifoWrPtr, fifoRdPtr, eqSetting, segMag_q;
   logic [41:0] segRestAmp;
   logic [2:0]  segIdx;
   logic [6:0]  segAmp, segment_one_amplitude, segment_two_amplitude;
   int          n_mismatch, cmp_count, i;
   liusr_regs u_dut (.*);
   liusr_host_model u_host (.*);
   // Clock
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;
   // Verdict
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task rdchk(input logic [4:0] a, input logic [7:0] e, input logic h);
      u_host.rd(a, rdData, rdHit);
      chk(rdData, e);
      chk({7'h00, rdHit}, {7'h00, h});
   endtask
   task tick;
      @(posedge core_clk);
      #1;
   endtask
   // Hang guard
   initial
   begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      end_of_test;
   end
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      src = 7'h00;
      irqEnable = 7'h00;
      fifoWrPtr = 6'h0a;
      fifoRdPtr = 6'h00;
      eqSetting = 6'h00;
      eqSettingValid = 1'b0;
      arbPulseMode = 1'b0;
      periodStart = 1'b0;
      segStep = 1'b0;
      segRestAmp = {7'h15, 7'h14, 7'h13, 7'h12, 7'h11, 7'h10};
      repeat (6) @(posedge core_clk);
      #1;
      rst = 1'b0;
      rdchk(5'h06, 8'h00, 1'b1);
      rdchk(5'h07, 8'h00, 1'b1);
      rdchk(5'h08, 8'h00, 1'b1);
      rdchk(5'h09, 8'h00, 1'b1);
      rdchk(5'h0a, 8'h00, 1'b0);
      $display("test reset values done");
      // Writes, read-only places, frozen clock enable
      u_host.wr(5'h08, 8'hff);
      u_host.wr(5'h09, 8'h41);
      u_host.wr(5'h06, 8'hff);
      u_host.wr(5'h07, 8'hff);
      ce = 1'b0;
      u_host.wr(5'h08, 8'h12);
      ce = 1'b1;
      rdchk(5'h08, 8'hff, 1'b1);
      rdchk(5'h09, 8'h41, 1'b1);
      rdchk(5'h06, 8'h00, 1'b1);
      rdchk(5'h07, 8'h00, 1'b1);
      chk({1'b0, segment_one_amplitude}, 8'h7f);
      chk({1'b0, segment_two_amplitude}, 8'h41);
      $display("test segment registers done");
      // Cable word loads only with its valid strobe
      tick;
      eqSetting = 6'h2d;
      eqSettingValid = 1'b1;
      tick;
      eqSettingValid = 1'b0;
      eqSetting = 6'h11;
      rdchk(5'h07, 8'h2d, 1'b1);
      $display("test cable word done");
      // One change per source; distance four is not yet the limit
      for (i = 0; i < 7; i++)
      begin
         tick;
         if (i == 5)
         begin
            fifoRdPtr = 6'h06;
            tick;
            fifoRdPtr = 6'h07;
         end
         else
            src[i] = ~src[i];
         rdchk(5'h06, 8'h01 << i, 1'b1);
         rdchk(5'h06, 8'h00, 1'b1);
      end
      $display("test change flags done");
      // Request follows enabled flags only
      irqEnable = 7'h02;
      tick;
      src[1] = ~src[1];
      tick;
      tick;
      chk({7'h00, irqRequest}, 8'h01);
      rdchk(5'h06, 8'h02, 1'b1);
      chk({7'h00, irqRequest}, 8'h00);
      src[0] = ~src[0];
      tick;
      tick;
      chk({7'h00, irqRequest}, 8'h00);
      rdchk(5'h06, 8'h01, 1'b1);
      // Change landing on the read edge survives the clear
      fork
         rdchk(5'h06, 8'h00, 1'b1);
         begin
            tick;
            src[0] = ~src[0];
         end
      join
      rdchk(5'h06, 8'h01, 1'b1);
      $display("test interrupt and race done");
      // Eight segments in arbitrary mode
      arbPulseMode = 1'b1;
      tick;
      periodStart = 1'b1;
      tick;
      periodStart = 1'b0;
      segStep = 1'b1;
      chk({segActive, segAmp}, 8'hff);
      for (i = 1; i < 8; i++)
      begin
         tick;
         chk({5'h00, segIdx}, i[7:0]);
         chk({segActive, segAmp}, {1'b1, (i == 1) ? 7'h41 : 7'h0e + i[6:0]});
         // Split lags one segment: shows the amplitude of index i-1
         chk({1'b0, segSign_q, segMag_q},
             (i == 1) ? 8'h7f : (i == 2) ? 8'h41 : 8'h0d + i[7:0]);
      end
      tick;
      segStep = 1'b0;
      chk({segActive, segAmp}, 8'h00);
      arbPulseMode = 1'b0;
      periodStart = 1'b1;
      tick;
      periodStart = 1'b0;
      tick;
      chk({segActive, segAmp}, 8'h00);
      $display("test pulse shaper done");
      end_of_test;
   end
endmodule
bind liusr_regs liusr_chk u_chk (.*);
